// *** logic/vendor_regs_pkg.sv ***
// Constants, encodings and carrier types for the vendor register bank
`default_nettype none
package vendor_regs_pkg;

  // Setup packet fields
  localparam logic [7:0] TYPE_GENERIC_WRITE = 8'h41;
  localparam logic [7:0] TYPE_GENERIC_READ = 8'hC1;
  localparam logic [7:0] TYPE_DEVICE_WRITE = 8'h40;
  localparam logic [7:0] TYPE_DEVICE_READ = 8'hC0;
  localparam logic [7:0] REQUEST_REGISTER = 8'h00;
  localparam logic [15:0] LENGTH_READ = 16'h0002;
  localparam logic [15:0] LENGTH_NONE = 16'h0000;
  localparam logic [7:0] CHANNEL_FIRST = 8'h00;
  localparam logic [7:0] CHANNEL_SECOND = 8'h02;
  localparam logic [15:0] INDEX_REVISION = 16'h0260;
  localparam logic [15:0] INDEX_LINK_STATUS = 16'h0262;

  // Register addresses, low index byte
  localparam logic [7:0] ADDR_PORT_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_HANDSHAKE = 8'h06;
  localparam logic [7:0] ADDR_RESUME_CHAR = 8'h07;
  localparam logic [7:0] ADDR_PAUSE_CHAR = 8'h08;
  localparam logic [7:0] ADDR_LINE_ERRORS = 8'h09;
  localparam logic [7:0] ADDR_BREAK_LENGTH = 8'h0A;
  localparam logic [7:0] ADDR_XCVR_DELAY = 8'h0B;
  localparam logic [7:0] ADDR_PIN_FUNCTION = 8'h0C;
  localparam logic [7:0] ADDR_PIN_DIRECTION = 8'h0D;
  localparam logic [7:0] ADDR_PIN_SET = 8'h0E;
  localparam logic [7:0] ADDR_PIN_CLEAR = 8'h0F;
  localparam logic [7:0] ADDR_PIN_LEVEL = 8'h10;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h11;
  localparam logic [7:0] ADDR_CUSTOM_EVENT = 8'h12;
  localparam int NUM_SLOTS = 19;

  // Implemented bits; everything else is reserved and reads zero
  localparam logic [15:0] MASK_PORT_ENABLE = 16'h0003;
  localparam logic [15:0] MASK_HANDSHAKE = 16'h000F;
  localparam logic [15:0] MASK_CHAR = 16'h00FF;
  localparam logic [15:0] MASK_LINE_ERRORS = 16'h00F8;
  localparam logic [15:0] MASK_FULL = 16'hFFFF;
  localparam logic [15:0] MASK_XCVR_DELAY = 16'h000F;
  localparam logic [15:0] MASK_PINS = 16'h03FF;
  localparam logic [15:0] MASK_PIN_LEVEL = 16'h0FFF;
  localparam logic [15:0] MASK_EVENT = 16'h07FF;
  localparam logic [15:0] MASK_CUSTOM_EVENT = 16'h0003;
  localparam logic [15:0] MASK_LINK_STATUS = 16'h3F3F;
  localparam logic [15:0] RESET_VALUE = 16'h0000;

  typedef enum logic [2:0] {
    KIND_NONE = 3'b000,
    KIND_RW = 3'b001,
    KIND_RC = 3'b010,
    KIND_W1S = 3'b011,
    KIND_W1C = 3'b100,
    KIND_RO = 3'b101
  } slot_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND_LOW = 2'b01,
    ST_SEND_HIGH = 2'b10
  } send_state_t;

  typedef struct packed {
    logic [7:0] request_type;
    logic [7:0] request;
    logic [15:0] value;
    logic [15:0] index;
    logic [15:0] length;
  } setup_t;

  typedef struct packed {
    logic [15:0] port_enable;
    logic [15:0] handshake;
    logic [15:0] resume_char;
    logic [15:0] pause_char;
    logic [15:0] break_length;
    logic [15:0] xcvr_delay;
    logic [15:0] pin_function;
    logic [15:0] pin_direction;
    logic [15:0] pin_out;
    logic [15:0] event_mask;
    logic [15:0] custom_event;
  } chan_cfg_t;

endpackage : vendor_regs_pkg
`default_nettype wire

// *** logic/usb_vendor_register_access.sv ***
// Vendor control-request decoder and two-channel register bank
`timescale 1ns/100ps
`default_nettype none

module usb_vendor_register_access #(
  parameter int CHANNELS = 2,
  parameter logic [15:0] SILICON_REVISION = 16'h0001 // Arbitrary value
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic setup_valid,
  input wire vendor_regs_pkg::setup_t setup,
  output logic in_valid,
  input wire logic in_ready,
  output logic [7:0] in_data,
  output logic in_last,
  output logic req_ack,
  output logic req_stall,
  output logic order_violation,
  input wire logic [CHANNELS-1:0][15:0] line_error_event,
  input wire logic [CHANNELS-1:0][15:0] pin_level_in,
  output vendor_regs_pkg::chan_cfg_t [CHANNELS-1:0] chan_cfg,
  output logic [15:0] link_status
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding

  function automatic vendor_regs_pkg::slot_kind_t slot_kind(input logic [7:0] addr);
    case (addr)
      vendor_regs_pkg::ADDR_PORT_ENABLE, vendor_regs_pkg::ADDR_HANDSHAKE,
      vendor_regs_pkg::ADDR_RESUME_CHAR, vendor_regs_pkg::ADDR_PAUSE_CHAR,
      vendor_regs_pkg::ADDR_BREAK_LENGTH, vendor_regs_pkg::ADDR_XCVR_DELAY,
      vendor_regs_pkg::ADDR_PIN_FUNCTION, vendor_regs_pkg::ADDR_PIN_DIRECTION,
      vendor_regs_pkg::ADDR_EVENT_MASK,
      vendor_regs_pkg::ADDR_CUSTOM_EVENT: slot_kind = vendor_regs_pkg::KIND_RW;
      vendor_regs_pkg::ADDR_LINE_ERRORS: slot_kind = vendor_regs_pkg::KIND_RC;
      vendor_regs_pkg::ADDR_PIN_SET: slot_kind = vendor_regs_pkg::KIND_W1S;
      vendor_regs_pkg::ADDR_PIN_CLEAR: slot_kind = vendor_regs_pkg::KIND_W1C;
      vendor_regs_pkg::ADDR_PIN_LEVEL: slot_kind = vendor_regs_pkg::KIND_RO;
      default: slot_kind = vendor_regs_pkg::KIND_NONE;
    endcase
  endfunction : slot_kind

  function automatic logic [15:0] slot_mask(input logic [7:0] addr);
    case (addr)
      vendor_regs_pkg::ADDR_PORT_ENABLE: slot_mask = vendor_regs_pkg::MASK_PORT_ENABLE;
      vendor_regs_pkg::ADDR_HANDSHAKE: slot_mask = vendor_regs_pkg::MASK_HANDSHAKE;
      vendor_regs_pkg::ADDR_RESUME_CHAR: slot_mask = vendor_regs_pkg::MASK_CHAR;
      vendor_regs_pkg::ADDR_PAUSE_CHAR: slot_mask = vendor_regs_pkg::MASK_CHAR;
      vendor_regs_pkg::ADDR_LINE_ERRORS: slot_mask = vendor_regs_pkg::MASK_LINE_ERRORS;
      vendor_regs_pkg::ADDR_BREAK_LENGTH: slot_mask = vendor_regs_pkg::MASK_FULL;
      vendor_regs_pkg::ADDR_XCVR_DELAY: slot_mask = vendor_regs_pkg::MASK_XCVR_DELAY;
      vendor_regs_pkg::ADDR_PIN_FUNCTION: slot_mask = vendor_regs_pkg::MASK_PINS;
      vendor_regs_pkg::ADDR_PIN_DIRECTION: slot_mask = vendor_regs_pkg::MASK_PINS;
      vendor_regs_pkg::ADDR_PIN_SET: slot_mask = vendor_regs_pkg::MASK_PINS;
      vendor_regs_pkg::ADDR_PIN_CLEAR: slot_mask = vendor_regs_pkg::MASK_PINS;
      vendor_regs_pkg::ADDR_PIN_LEVEL: slot_mask = vendor_regs_pkg::MASK_PIN_LEVEL;
      vendor_regs_pkg::ADDR_EVENT_MASK: slot_mask = vendor_regs_pkg::MASK_EVENT;
      vendor_regs_pkg::ADDR_CUSTOM_EVENT: slot_mask = vendor_regs_pkg::MASK_CUSTOM_EVENT;
      default: slot_mask = 16'h0000;
    endcase
  endfunction : slot_mask

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  logic [7:0] addr;
  logic [7:0] chan_byte;
  logic chan_ok;
  logic chan_sel;
  vendor_regs_pkg::slot_kind_t kind;
  logic [15:0] wmask;
  logic generic_write;
  logic generic_read;
  logic revision_read;
  logic link_write;
  logic link_read;
  logic exempt;

  always_comb begin
    addr = setup.index[7:0];
    chan_byte = setup.index[15:8];
    chan_ok = (chan_byte == vendor_regs_pkg::CHANNEL_FIRST) ||
              (chan_byte == vendor_regs_pkg::CHANNEL_SECOND);
    chan_sel = (chan_byte == vendor_regs_pkg::CHANNEL_SECOND);
    kind = slot_kind(addr);
    wmask = slot_mask(addr);
    generic_write = setup_valid && chan_ok &&
                    setup.request_type == vendor_regs_pkg::TYPE_GENERIC_WRITE &&
                    setup.request == vendor_regs_pkg::REQUEST_REGISTER &&
                    setup.length == vendor_regs_pkg::LENGTH_NONE &&
                    kind != vendor_regs_pkg::KIND_NONE && kind != vendor_regs_pkg::KIND_RO;
    generic_read = setup_valid && chan_ok &&
                   setup.request_type == vendor_regs_pkg::TYPE_GENERIC_READ &&
                   setup.request == vendor_regs_pkg::REQUEST_REGISTER &&
                   setup.length == vendor_regs_pkg::LENGTH_READ &&
                   (kind == vendor_regs_pkg::KIND_RW || kind == vendor_regs_pkg::KIND_RC ||
                    kind == vendor_regs_pkg::KIND_RO);
    revision_read = setup_valid &&
                    setup.request_type == vendor_regs_pkg::TYPE_DEVICE_READ &&
                    setup.request == vendor_regs_pkg::REQUEST_REGISTER &&
                    setup.index == vendor_regs_pkg::INDEX_REVISION &&
                    setup.length == vendor_regs_pkg::LENGTH_READ;
    link_read = setup_valid &&
                setup.request_type == vendor_regs_pkg::TYPE_DEVICE_READ &&
                setup.request == vendor_regs_pkg::REQUEST_REGISTER &&
                setup.index == vendor_regs_pkg::INDEX_LINK_STATUS &&
                setup.length == vendor_regs_pkg::LENGTH_READ;
    link_write = setup_valid &&
                 setup.request_type == vendor_regs_pkg::TYPE_DEVICE_WRITE &&
                 setup.request == vendor_regs_pkg::REQUEST_REGISTER &&
                 setup.index == vendor_regs_pkg::INDEX_LINK_STATUS &&
                 setup.length == vendor_regs_pkg::LENGTH_NONE;
    exempt = kind == vendor_regs_pkg::KIND_RC || kind == vendor_regs_pkg::KIND_W1S ||
             kind == vendor_regs_pkg::KIND_W1C ||
             addr == vendor_regs_pkg::ADDR_BREAK_LENGTH;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bank

  logic [15:0] bank_q [CHANNELS][vendor_regs_pkg::NUM_SLOTS];
  logic [15:0] bank_d [CHANNELS][vendor_regs_pkg::NUM_SLOTS];
  logic [15:0] link_q;
  logic [15:0] link_d;
  logic [15:0] read_word;
  logic violation_d;

  always_comb begin
    bank_d = bank_q;
    link_d = link_q;
    read_word = 16'h0000;
    violation_d = 1'b0;
    // Read value is captured before any clear-on-read takes effect
    if (generic_read) begin
      if (kind == vendor_regs_pkg::KIND_RO) begin
        read_word = pin_level_in[chan_sel] & wmask;
      end else begin
        read_word = bank_q[chan_sel][addr[4:0]] & wmask;
      end
    end else if (revision_read) begin
      read_word = SILICON_REVISION;
    end else if (link_read) begin
      read_word = link_q;
    end
    if (generic_write) begin
      case (kind)
        vendor_regs_pkg::KIND_RW: begin
          bank_d[chan_sel][addr[4:0]] = setup.value & wmask;
        end
        vendor_regs_pkg::KIND_RC: begin
          bank_d[chan_sel][addr[4:0]] = bank_q[chan_sel][addr[4:0]] & ~(setup.value & wmask);
        end
        vendor_regs_pkg::KIND_W1S: begin
          bank_d[chan_sel][vendor_regs_pkg::ADDR_PIN_SET[4:0]] =
            bank_q[chan_sel][vendor_regs_pkg::ADDR_PIN_SET[4:0]] | (setup.value & wmask);
        end
        vendor_regs_pkg::KIND_W1C: begin
          // Set and clear strobes share one output latch kept in the set slot
          bank_d[chan_sel][vendor_regs_pkg::ADDR_PIN_SET[4:0]] =
            bank_q[chan_sel][vendor_regs_pkg::ADDR_PIN_SET[4:0]] & ~(setup.value & wmask);
        end
        default: begin
        end
      endcase
      // Ordinary write while the port runs is still stored but flagged
      violation_d = !exempt &&
                    addr != vendor_regs_pkg::ADDR_PORT_ENABLE &&
                    bank_q[chan_sel][vendor_regs_pkg::ADDR_PORT_ENABLE[4:0]] != 16'h0000;
    end
    if (generic_read && kind == vendor_regs_pkg::KIND_RC) begin
      bank_d[chan_sel][addr[4:0]] = 16'h0000;
    end
    // Line error events win over any clear in the same cycle
    for (int c = 0; c < CHANNELS; c++) begin
      bank_d[c][vendor_regs_pkg::ADDR_LINE_ERRORS[4:0]] =
        bank_d[c][vendor_regs_pkg::ADDR_LINE_ERRORS[4:0]] |
        (line_error_event[c] & vendor_regs_pkg::MASK_LINE_ERRORS);
    end
    if (link_write) begin
      link_d = setup.value & vendor_regs_pkg::MASK_LINK_STATUS;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < CHANNELS; c++) begin
        for (int s = 0; s < vendor_regs_pkg::NUM_SLOTS; s++) begin
          bank_q[c][s] <= vendor_regs_pkg::RESET_VALUE;
        end
      end
      link_q <= vendor_regs_pkg::RESET_VALUE;
    end else begin
      bank_q <= bank_d;
      link_q <= link_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data stage and status handshake

  vendor_regs_pkg::send_state_t state_q;
  vendor_regs_pkg::send_state_t state_d;
  logic [15:0] word_q;
  logic [15:0] word_d;
  logic [7:0] byte_q;
  logic [7:0] byte_d;
  logic ack_q;
  logic ack_d;
  logic stall_q;
  logic stall_d;
  logic violation_q;
  logic any_read;

  always_comb begin
    any_read = generic_read || revision_read || link_read;
    state_d = state_q;
    word_d = word_q;
    byte_d = byte_q;
    ack_d = 1'b0;
    stall_d = 1'b0;
    // A new setup aborts any data stage still in progress
    if (setup_valid) begin
      if (any_read) begin
        state_d = vendor_regs_pkg::ST_SEND_LOW;
        word_d = read_word;
        byte_d = read_word[7:0];
      end else begin
        state_d = vendor_regs_pkg::ST_IDLE;
        ack_d = generic_write || link_write;
        stall_d = !(generic_write || link_write);
      end
    end else begin
      case (state_q)
        vendor_regs_pkg::ST_IDLE: begin
        end
        vendor_regs_pkg::ST_SEND_LOW: begin
          if (in_ready) begin
            state_d = vendor_regs_pkg::ST_SEND_HIGH;
            byte_d = word_q[15:8];
          end
        end
        vendor_regs_pkg::ST_SEND_HIGH: begin
          if (in_ready) begin
            state_d = vendor_regs_pkg::ST_IDLE;
            ack_d = 1'b1;
          end
        end
        default: begin
          state_d = vendor_regs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= vendor_regs_pkg::ST_IDLE;
      word_q <= 16'h0000;
      byte_q <= 8'h00;
      ack_q <= 1'b0;
      stall_q <= 1'b0;
      violation_q <= 1'b0;
    end else begin
      state_q <= state_d;
      word_q <= word_d;
      byte_q <= byte_d;
      ack_q <= ack_d;
      stall_q <= stall_d;
      violation_q <= violation_d;
    end
  end

  assign in_valid = (state_q == vendor_regs_pkg::ST_SEND_LOW) ||
                    (state_q == vendor_regs_pkg::ST_SEND_HIGH);
  assign in_last = (state_q == vendor_regs_pkg::ST_SEND_HIGH);
  assign in_data = byte_q;
  assign req_ack = ack_q;
  assign req_stall = stall_q;
  assign order_violation = violation_q;
  assign link_status = link_q;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration seen by the serial channels

  for (genvar c = 0; c < CHANNELS; c++) begin : g_cfg
    assign chan_cfg[c].port_enable = bank_q[c][vendor_regs_pkg::ADDR_PORT_ENABLE[4:0]];
    assign chan_cfg[c].handshake = bank_q[c][vendor_regs_pkg::ADDR_HANDSHAKE[4:0]];
    assign chan_cfg[c].resume_char = bank_q[c][vendor_regs_pkg::ADDR_RESUME_CHAR[4:0]];
    assign chan_cfg[c].pause_char = bank_q[c][vendor_regs_pkg::ADDR_PAUSE_CHAR[4:0]];
    assign chan_cfg[c].break_length = bank_q[c][vendor_regs_pkg::ADDR_BREAK_LENGTH[4:0]];
    assign chan_cfg[c].xcvr_delay = bank_q[c][vendor_regs_pkg::ADDR_XCVR_DELAY[4:0]];
    assign chan_cfg[c].pin_function = bank_q[c][vendor_regs_pkg::ADDR_PIN_FUNCTION[4:0]];
    assign chan_cfg[c].pin_direction = bank_q[c][vendor_regs_pkg::ADDR_PIN_DIRECTION[4:0]];
    assign chan_cfg[c].pin_out = bank_q[c][vendor_regs_pkg::ADDR_PIN_SET[4:0]];
    assign chan_cfg[c].event_mask = bank_q[c][vendor_regs_pkg::ADDR_EVENT_MASK[4:0]];
    assign chan_cfg[c].custom_event = bank_q[c][vendor_regs_pkg::ADDR_CUSTOM_EVENT[4:0]];
  end

endmodule : usb_vendor_register_access
`default_nettype wire

// *** tb/usb_vendor_register_access_monitor.sv ***
// Port checker for the vendor register bank
`timescale 1ns/100ps
`default_nettype none
module usb_vendor_register_access_monitor #(
  parameter int CHANNELS = 2
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic setup_valid,
  input wire vendor_regs_pkg::setup_t setup,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  input wire logic req_ack,
  input wire logic req_stall,
  input wire logic order_violation,
  input wire logic [CHANNELS-1:0][15:0] line_error_event,
  input wire logic [CHANNELS-1:0][15:0] pin_level_in,
  input wire vendor_regs_pkg::chan_cfg_t [CHANNELS-1:0] chan_cfg,
  input wire logic [15:0] link_status
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire logic ok0 = setup_valid && setup.request == 8'h00;
  wire logic gw = ok0 && setup.request_type == 8'h41 && setup.length == 16'h0000;
  wire logic gen = setup_valid && setup.request_type[5:0] == 6'h01;
  wire logic chb = setup.index[15:8] != 8'h00 && setup.index[15:8] != 8'h02;
  wire logic lw = ok0 && setup.request_type == 8'h40 && setup.index == 16'h0262;
  wire logic gr = ok0 && setup.request_type == 8'hC1 && setup.length == 16'h0002;

  write_answer_a: assert property (gw |=> req_ack || req_stall)
    else $error("write not answered");
  bad_channel_a: assert property (setup_valid && chb |=> req_stall)
    else $error("bad channel not stalled");
  generic_special_a: assert property (gen && setup.index inside {16'h0260, 16'h0262}
    |=> req_stall) else $error("generic access to special word");
  read_start_a: assert property (gr && setup.index inside {16'h0000, 16'h0006}
    |=> in_valid && !in_last) else $error("read did not start");
  exempt_run_a: assert property (gw && setup.index[7:0] inside {8'h09, 8'h0A, 8'h0E, 8'h0F}
    |=> !order_violation) else $error("exempt write flagged");
  low_first_a: assert property ($rose(in_valid) |-> !in_last)
    else $error("high byte sent first");
  high_next_a: assert property (in_valid && !in_last && in_ready && !setup_valid
    |=> in_valid && in_last) else $error("high byte missing");
  read_done_a: assert property (in_valid && in_last && in_ready && !setup_valid
    |=> !in_valid && req_ack) else $error("read not closed");
  reserved_zero_a: assert property (chan_cfg[0].port_enable[15:2] == 14'h0000
    && chan_cfg[CHANNELS-1].custom_event[15:2] == 14'h0000) else $error("reserved bits set");
  link_store_a: assert property (lw && setup.length == 16'h0000 |=> req_ack
    && link_status == ($past(setup.value) & 16'h3F3F)) else $error("link word not stored");
endmodule : usb_vendor_register_access_monitor
`default_nettype wire

// *** tb/usb_host_model.sv ***
// Host side model issuing vendor control transfers
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
  input wire logic clock,
  output logic setup_valid,
  output vendor_regs_pkg::setup_t setup,
  output logic in_ready,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic req_ack,
  input wire logic req_stall
);
  initial begin
    setup_valid = 1'b0;
    setup = '0;
    in_ready = 1'b0;
  end
  // Entered just after a rising edge; returns just after one
  task automatic xfer(input vendor_regs_pkg::setup_t s, input int slow,
    output logic [15:0] rd, output logic ok);
    int n;
    rd = 16'h0000;
    // One idle edge so strobes are never reassigned within one time step
    @(posedge clock);
    #1;
    setup = s;
    setup_valid = 1'b1;
    @(posedge clock);
    #1;
    setup_valid = 1'b0;
    // Released field carries junk so stale values are never trusted
    setup = ~s;
    if (s.request_type[7] && !req_stall) begin
      for (int b = 0; b < 2; b++) begin
        n = 0;
        while (!in_valid && n < 20) begin
          @(posedge clock);
          #1;
          n++;
        end
        if (slow > 0) begin
          in_ready = 1'b0;
          repeat (slow) begin
            @(posedge clock);
            #1;
          end
        end
        rd[8*b+:8] = in_data;
        in_ready = 1'b1;
        @(posedge clock);
        #1;
      end
      in_ready = 1'b0;
    end
    ok = req_ack;
  endtask : xfer
endmodule : usb_host_model
`default_nettype wire

// *** tb/usb_vendor_register_access_tb.sv ***
// Self-checking bench for the vendor register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module usb_vendor_register_access_tb;
  localparam logic [15:0] REV = 16'h00A5; // Arbitrary value
  logic clock, rstn, setup_valid, in_valid, in_ready, in_last, ok;
  logic req_ack, req_stall, order_violation;
  logic [7:0] in_data;
  logic [15:0] link_status, data;
  logic [1:0][15:0] line_error_event, pin_level_in;
  vendor_regs_pkg::setup_t setup;
  vendor_regs_pkg::chan_cfg_t [1:0] chan_cfg;
  int n_errors = 0;
  int num_checks = 0;

  usb_vendor_register_access #(.CHANNELS(2), .SILICON_REVISION(REV))
    i_usb_vendor_register_access (.clock(clock), .rstn(rstn), .setup_valid(setup_valid),
    .setup(setup), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .in_last(in_last), .req_ack(req_ack), .req_stall(req_stall),
    .order_violation(order_violation), .line_error_event(line_error_event),
    .pin_level_in(pin_level_in), .chan_cfg(chan_cfg), .link_status(link_status));
  usb_host_model i_usb_host_model (.clock(clock), .setup_valid(setup_valid), .setup(setup),
    .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data), .req_ack(req_ack),
    .req_stall(req_stall));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic req(input logic [7:0] ty, input logic [15:0] v, input logic [15:0] idx,
    input int slow);
    i_usb_host_model.xfer({ty, 8'h00, v, idx, ty[7] ? 16'h0002 : 16'h0000}, slow, data, ok);
  endtask : req
  task automatic wr(input logic [7:0] ch, input logic [7:0] a, input logic [15:0] v);
    req(8'h41, v, {ch, a}, 0);
  endtask : wr
  task automatic get(input logic [7:0] ch, input logic [7:0] a);
    req(8'hC1, 16'h0000, {ch, a}, 0);
  endtask : get
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_bank();
    logic [7:0] a [9] = '{8'h06, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h11, 8'h12};
    logic [15:0] m [9] = '{16'h000F, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h000F, 16'h03FF,
      16'h03FF, 16'h07FF, 16'h0003};
    for (int i = 0; i < 9; i++) begin
      get(8'h00, a[i]);
      `CHK({ok, data}, {1'b1, 16'h0000})
      wr(8'h00, a[i], m[i]);
      wr(8'h02, a[i], m[i] & 16'h5555);
      get(8'h00, a[i]);
      `CHK({ok, data}, {1'b1, m[i]})
      get(8'h02, a[i]);
      `CHK({ok, data}, {1'b1, m[i] & 16'h5555})
    end
    `CHK(chan_cfg[1].xcvr_delay, 16'h0005)
  endtask : t_bank
  task automatic t_order();
    logic [7:0] a [4] = '{8'h0E, 8'h0F, 8'h0A, 8'h09};
    logic [15:0] v [4] = '{16'h0005, 16'h0001, 16'h1234, 16'h00F8};
    wr(8'h00, 8'h00, 16'h0003);
    `CHK({ok, order_violation}, 2'b10)
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, a[i], v[i]);
      `CHK({ok, order_violation}, 2'b10)
    end
    `CHK({chan_cfg[0].pin_out, chan_cfg[0].break_length}, {16'h0004, 16'h1234})
    wr(8'h00, 8'h06, 16'h0001);
    `CHK({ok, order_violation}, 2'b11)
    wr(8'h00, 8'h00, 16'h0000);
  endtask : t_order
  task automatic t_flags();
    line_error_event[0] = 16'hFFFF;
    pin_level_in[1] = 16'hFABC;
    @(posedge clock);
    #1;
    line_error_event[0] = 16'h0000;
    get(8'h00, 8'h09);
    `CHK({ok, data}, {1'b1, 16'h00F8})
    get(8'h00, 8'h09);
    `CHK({ok, data}, {1'b1, 16'h0000})
    get(8'h02, 8'h10);
    `CHK({ok, data}, {1'b1, 16'h0ABC})
  endtask : t_flags
  task automatic t_special();
    logic [7:0] ty [6] = '{8'hC1, 8'h41, 8'hC1, 8'hC1, 8'hC1, 8'h40};
    logic [15:0] ix [6] = '{16'h0260, 16'h0262, 16'h000E, 16'h0106, 16'h0003, 16'h0260};
    req(8'hC0, 16'h0000, 16'h0260, 0);
    `CHK({ok, data}, {1'b1, REV})
    req(8'h40, 16'h2A15, 16'h0262, 0);
    `CHK({ok, link_status}, {1'b1, 16'h2A15})
    req(8'hC0, 16'h0000, 16'h0262, 3);
    `CHK({ok, data}, {1'b1, 16'h2A15})
    for (int i = 0; i < 6; i++) begin
      req(ty[i], 16'h0000, ix[i], 0);
      `CHK({ok, req_stall}, 2'b01)
    end
    i_usb_host_model.xfer({8'hC1, 8'h01, 16'h0000, 16'h0006, 16'h0002}, 0, data, ok);
    `CHK({ok, req_stall}, 2'b01)
    i_usb_host_model.xfer({8'h41, 8'h00, 16'h0001, 16'h0006, 16'h0002}, 0, data, ok);
    `CHK({ok, req_stall, chan_cfg[0].handshake}, {2'b01, 16'h0001})
  endtask : t_special
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    line_error_event = '0;
    pin_level_in = '0;
    repeat (10) @(posedge clock);
    #1;
    rstn = 1'b1;
    t_bank();
    t_order();
    t_flags();
    t_special();
    end_of_test();
  end
  initial begin
    #50000;
    n_errors++;
    end_of_test();
  end
endmodule : usb_vendor_register_access_tb

bind usb_vendor_register_access usb_vendor_register_access_monitor #(.CHANNELS(CHANNELS))
  i_usb_vendor_register_access_monitor (.clock(clock), .rstn(rstn),
  .setup_valid(setup_valid), .setup(setup), .in_valid(in_valid), .in_ready(in_ready),
  .in_data(in_data), .in_last(in_last), .req_ack(req_ack), .req_stall(req_stall),
  .order_violation(order_violation), .line_error_event(line_error_event),
  .pin_level_in(pin_level_in), .chan_cfg(chan_cfg), .link_status(link_status));
`default_nettype wire
